//--- logic/spi_flash_consts.svh
/*
 Constants of the serial flash command logic: instruction codes, status
 byte layout, identification bytes, byte counts and busy timing.
 Assumes inclusion by bare name from files under logic/.
*/
`ifndef SPI_FLASH_CONSTS_SVH
`define SPI_FLASH_CONSTS_SVH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_READ_ID 8'h9f
`define OPC_READ_STATUS 8'h05
`define OPC_WRITE_STATUS 8'h01
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_SECTOR_WIPE 8'hd8
`define OPC_BULK_ERASE 8'hc7

// ----------------------------------------
// Status byte layout and reset values
// ----------------------------------------
`define SR_BUSY_BIT 0
`define SR_LATCH_BIT 1
`define SR_BP_LSB 2
`define SR_BP_MSB 4
`define SR_LOCK_BIT 7
`define SR_BP_RESET 3'h0
`define SR_LOCK_RESET 1'h0

// ----------------------------------------
// Identification readout
// ----------------------------------------
`define ID_IDX_MANUF 5'h00
`define ID_IDX_TYPE 5'h01
`define ID_IDX_CAP 5'h02
`define ID_IDX_LEN 5'h03
`define ID_IDX_CUSTOM 5'h04
`define ID_TOTAL 5'h14
`define ID_LEN_BYTE 8'h10
`define CUSTOM_BLANK 8'h00

// ----------------------------------------
// Byte counts at chip select release
// ----------------------------------------
`define LEN_SINGLE 3'h1
`define LEN_STATUS_WR 3'h2
`define LEN_SECTOR 3'h4
`define LEN_PAGE_MIN 3'h5
`define LEN_SAT 3'h7

// ----------------------------------------
// Pins and timing
// ----------------------------------------
`define PINS_IDLE 4'h9
`define CLK_PERIOD_NS 10
`define BUSY_TIME_NS 20000
`define BUSY_CYCLES (`BUSY_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- logic/spi_flash_pkg.sv
/*
 Types shared by the serial flash command logic.
 Assumes the constants header is compiled alongside.
*/
package spi_flash_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_CMD  = 5'b00010,
		ST_OUT  = 5'b00100,
		ST_IN   = 5'b01000,
		ST_SKIP = 5'b10000
	} link_state_t;

	typedef enum logic [1:0] {
		OP_STATUS  = 2'h0,
		OP_PROGRAM = 2'h1,
		OP_SECTOR  = 2'h2,
		OP_BULK    = 2'h3
	} op_kind_t;

	typedef struct packed {
		logic valid;
		op_kind_t kind;
		logic [23:0] addr;
	} op_start_t;

	typedef struct packed {
		logic cs_b;
		logic sclk;
		logic mosi;
		logic wp_b;
	} spi_pins_t;

endpackage

//--- logic/byte_skid_buffer.sv
/*
 Two-entry buffer with valid and ready on both sides and a flush.
 Assumes one clock domain and a flush only between transfers.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_skid_buffer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic flush_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	input wire logic out_ready_i,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o
);

	logic [WIDTH-1:0] mem_q [2];
	logic wr_q;
	logic rd_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready_o = (count_q != 2'h2);
	assign out_valid_o = (count_q != 2'h0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge mclk_i)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			count_q <= 2'h0;
		end
		else if (flush_i)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			count_q <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				wr_q <= ~wr_q;
			end
			if (pop)
			begin
				rd_q <= ~rd_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

`default_nettype wire

//--- logic/spi_flash_wel_id_status_logic.sv
/*
 Command logic of a serial flash: write enable latch, identification
 readout, status read and protection bits, with a timed busy cycle.
 Assumes SPI mode 0 pins from outside, sampled by mclk_i, and array
 logic on mclk_i that reports protection of the captured address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_consts.svh"

module spi_flash_wel_id_status_logic
	import spi_flash_pkg::*;
#(
	parameter int unsigned BUSY_CYCLES = `BUSY_CYCLES,
	parameter logic [7:0] MANUF_CODE = 8'ha5,   // Arbitrary value
	parameter logic [7:0] TYPE_CODE = 8'h3c,    // Arbitrary value
	parameter logic [7:0] CAP_CODE = 8'h18,     // Arbitrary value
	parameter logic [127:0] CUSTOM_DATA = {16{`CUSTOM_BLANK}}
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Serial link pins
	input wire logic cs_b_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	input wire logic wp_b_i,
	output logic miso_o,
	output logic miso_oe_o,
	// Array side
	input wire logic prot_hit_i,
	output logic [23:0] target_addr_o,
	output op_start_t op_start_o,
	output logic [7:0] status_o
);

	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	spi_pins_t pins_in;
	spi_pins_t meta_q;
	spi_pins_t sync_q;
	spi_pins_t prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_fall;
	logic hardware_protected_mode;

	assign pins_in = '{cs_b: cs_b_i, sclk: sclk_i, mosi: mosi_i, wp_b: wp_b_i};

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= `PINS_IDLE;
			sync_q <= `PINS_IDLE;
			prev_q <= `PINS_IDLE;
		end
		else
		begin
			meta_q <= pins_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign sclk_rise = sync_q.sclk & ~prev_q.sclk & ~sync_q.cs_b;
	assign sclk_fall = ~sync_q.sclk & prev_q.sclk & ~sync_q.cs_b;
	assign cs_rise = sync_q.cs_b & ~prev_q.cs_b;
	assign cs_fall = ~sync_q.cs_b & prev_q.cs_b;

	// ----------------------------------------
	// Status state
	// ----------------------------------------
	link_state_t state_q;
	logic wel_q;
	logic busy_q;
	logic lock_q;
	logic [2:0] bp_q;
	logic [15:0] cnt_q;
	op_kind_t kind_q;
	logic [7:0] pend_sr_q;
	logic busy_done;
	logic [7:0] status_now;

	function automatic logic [7:0] status_pack(input logic lock, input logic [2:0] bp,
		input logic wel, input logic busy);
		logic [7:0] s;
		s = 8'h00;
		s[`SR_LOCK_BIT] = lock;
		s[`SR_BP_MSB:`SR_BP_LSB] = bp;
		s[`SR_LATCH_BIT] = wel;
		s[`SR_BUSY_BIT] = busy;
		return s;
	endfunction

	assign hardware_protected_mode = lock_q & ~sync_q.wp_b;
	assign busy_done = busy_q & (cnt_q == 16'h0000);
	assign status_now = status_pack(lock_q, bp_q, wel_q, busy_q);

	// ----------------------------------------
	// Receive shifter and opcode decode
	// ----------------------------------------
	logic [7:0] rx_sh_q;
	logic [7:0] rx_byte;
	logic [2:0] bit_q;
	logic [2:0] byte_q;
	logic [7:0] opcode_q;
	logic [23:0] addr_q;
	logic [7:0] wr_data_q;
	logic byte_end;
	link_state_t cmd_next;
	logic to_out;

	assign rx_byte = {rx_sh_q[6:0], sync_q.mosi};
	assign byte_end = sclk_rise & (bit_q == 3'h7);

	always_comb
	begin
		cmd_next = ST_SKIP;
		if (rx_byte == `OPC_READ_STATUS)
		begin
			cmd_next = ST_OUT;
		end
		else if (!busy_q)
		begin
			case (rx_byte)
				`OPC_READ_ID: cmd_next = ST_OUT;
				`OPC_WRITE_ENABLE, `OPC_WRITE_DISABLE, `OPC_WRITE_STATUS,
				`OPC_PAGE_PROGRAM, `OPC_SECTOR_WIPE, `OPC_BULK_ERASE: cmd_next = ST_IN;
				default: cmd_next = ST_SKIP;
			endcase
		end
	end

	assign to_out = byte_end & (state_q == ST_CMD) & (cmd_next == ST_OUT);

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
		end
		else if (cs_rise)
		begin
			state_q <= ST_IDLE;
		end
		else if (cs_fall)
		begin
			state_q <= ST_CMD;
		end
		else if (byte_end && state_q == ST_CMD)
		begin
			state_q <= cmd_next;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rx_sh_q <= 8'h00;
			bit_q <= 3'h0;
			byte_q <= 3'h0;
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
			wr_data_q <= 8'h00;
		end
		else if (cs_fall)
		begin
			bit_q <= 3'h0;
			byte_q <= 3'h0;
		end
		else if (sclk_rise)
		begin
			rx_sh_q <= rx_byte;
			bit_q <= bit_q + 3'h1;
			if (byte_end && byte_q != `LEN_SAT)
			begin
				byte_q <= byte_q + 3'h1;
			end
			if (byte_end && byte_q == 3'h0)
			begin
				opcode_q <= rx_byte;
			end
			if (byte_end && state_q == ST_IN && byte_q != 3'h0 && byte_q < `LEN_SECTOR)
			begin
				addr_q <= {addr_q[15:0], rx_byte};
			end
			if (byte_end && state_q == ST_IN && byte_q == 3'h1)
			begin
				wr_data_q <= rx_byte;
			end
		end
	end

	// ----------------------------------------
	// Execution at chip select release
	// ----------------------------------------
	logic at_boundary;
	logic do_write_enable_cmd;
	logic do_write_disable_cmd;
	logic start_sr;
	logic start_pp;
	logic start_se;
	logic start_be;
	logic start_any;

	assign at_boundary = cs_rise & (state_q == ST_IN) & (bit_q == 3'h0);
	assign do_write_enable_cmd = at_boundary & (opcode_q == `OPC_WRITE_ENABLE) & (byte_q == `LEN_SINGLE);
	assign do_write_disable_cmd = at_boundary & (opcode_q == `OPC_WRITE_DISABLE) & (byte_q == `LEN_SINGLE);
	assign start_sr = at_boundary & (opcode_q == `OPC_WRITE_STATUS) &
		(byte_q == `LEN_STATUS_WR) & wel_q & ~hardware_protected_mode;
	assign start_pp = at_boundary & (opcode_q == `OPC_PAGE_PROGRAM) &
		(byte_q >= `LEN_PAGE_MIN) & wel_q & ~prot_hit_i;
	assign start_se = at_boundary & (opcode_q == `OPC_SECTOR_WIPE) &
		(byte_q == `LEN_SECTOR) & wel_q & ~prot_hit_i;
	assign start_be = at_boundary & (opcode_q == `OPC_BULK_ERASE) &
		(byte_q == `LEN_SINGLE) & wel_q & (bp_q == 3'h0);
	assign start_any = start_sr | start_pp | start_se | start_be;

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wel_q <= 1'b0;
		end
		else if (busy_done || do_write_disable_cmd)
		begin
			wel_q <= 1'b0;
		end
		else if (do_write_enable_cmd)
		begin
			wel_q <= 1'b1;
		end
	end

	// Busy timer stands in for the array cycle, whose length is not modelled
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			busy_q <= 1'b0;
			cnt_q <= 16'h0000;
			kind_q <= OP_STATUS;
			pend_sr_q <= 8'h00;
		end
		else if (start_any)
		begin
			busy_q <= 1'b1;
			cnt_q <= 16'(BUSY_CYCLES - 1);
			kind_q <= start_sr ? OP_STATUS : start_pp ? OP_PROGRAM :
				start_se ? OP_SECTOR : OP_BULK;
			pend_sr_q <= wr_data_q;
		end
		else if (busy_done)
		begin
			busy_q <= 1'b0;
		end
		else if (busy_q)
		begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end

	// Reset value stands for the stored non-volatile contents
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lock_q <= `SR_LOCK_RESET;
			bp_q <= `SR_BP_RESET;
		end
		else if (busy_done && kind_q == OP_STATUS)
		begin
			lock_q <= pend_sr_q[`SR_LOCK_BIT];
			bp_q <= pend_sr_q[`SR_BP_MSB:`SR_BP_LSB];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			op_start_o <= '0;
			status_o <= 8'h00;
		end
		else
		begin
			op_start_o.valid <= start_any;
			op_start_o.kind <= start_sr ? OP_STATUS : start_pp ? OP_PROGRAM :
				start_se ? OP_SECTOR : OP_BULK;
			op_start_o.addr <= addr_q;
			status_o <= status_now;
		end
	end

	assign target_addr_o = addr_q;

	// ----------------------------------------
	// Byte source, buffer and serializer
	// ----------------------------------------
	logic src_active_q;
	logic src_id_q;
	logic [4:0] idx_q;
	logic [7:0] push_data;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [7:0] buf_out_data;
	logic pop;
	logic [2:0] out_bit_q;
	logic [7:0] out_sh_q;
	logic [7:0] next_byte;

	function automatic logic [7:0] id_byte(input logic [4:0] idx);
		logic [7:0] b;
		logic [3:0] k;
		b = `CUSTOM_BLANK;
		k = 4'(idx - `ID_IDX_CUSTOM);
		if (idx == `ID_IDX_MANUF)
			b = MANUF_CODE;
		else if (idx == `ID_IDX_TYPE)
			b = TYPE_CODE;
		else if (idx == `ID_IDX_CAP)
			b = CAP_CODE;
		else if (idx == `ID_IDX_LEN)
			b = `ID_LEN_BYTE;
		else if (idx < `ID_TOTAL)
			b = CUSTOM_DATA[{~k, 3'b000} +: 8];
		return b;
	endfunction

	// Buffered status may lag the live bits by up to two bytes
	assign push_data = src_id_q ? id_byte(idx_q) : status_now;

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			src_active_q <= 1'b0;
			src_id_q <= 1'b0;
			idx_q <= 5'h00;
		end
		else if (cs_rise)
		begin
			src_active_q <= 1'b0;
		end
		else if (to_out)
		begin
			src_active_q <= 1'b1;
			src_id_q <= (rx_byte == `OPC_READ_ID);
			idx_q <= 5'h00;
		end
		else if (src_active_q && buf_in_ready && src_id_q && idx_q != `ID_TOTAL)
		begin
			idx_q <= idx_q + 5'h01;
		end
	end

	assign pop = sclk_fall & (state_q == ST_OUT) & (out_bit_q == 3'h0);
	assign next_byte = buf_out_valid ? buf_out_data : 8'h00;

	byte_skid_buffer #(.WIDTH(8)) u_out_buf (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.flush_i(cs_rise | to_out),
		.in_valid_i(src_active_q),
		.in_data_i(push_data),
		.in_ready_o(buf_in_ready),
		.out_ready_i(pop),
		.out_valid_o(buf_out_valid),
		.out_data_o(buf_out_data)
	);

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			out_bit_q <= 3'h0;
			out_sh_q <= 8'h00;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end
		else if (cs_rise || cs_fall)
		begin
			out_bit_q <= 3'h0;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end
		else if (sclk_fall && state_q == ST_OUT)
		begin
			out_bit_q <= out_bit_q + 3'h1;
			miso_oe_o <= 1'b1;
			if (out_bit_q == 3'h0)
			begin
				miso_o <= next_byte[7];
				out_sh_q <= {next_byte[6:0], 1'b0};
			end
			else
			begin
				miso_o <= out_sh_q[7];
				out_sh_q <= {out_sh_q[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	property p_write_enable_cmd_sets;
		do_write_enable_cmd |=> wel_q && status_now[`SR_LATCH_BIT];
	endproperty
	a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets) else $error("latch not set");

	property p_write_disable_cmd_clears;
		do_write_disable_cmd |=> !wel_q;
	endproperty
	a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears) else $error("latch not cleared");

	property p_done_clears;
		busy_q && cnt_q == 16'h0000 |=> !wel_q && !busy_q;
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("cycle end kept latch");

	property p_start_needs_wel;
		$rose(op_start_o.valid) |-> $past(wel_q) && busy_q;
	endproperty
	a_start_needs_wel: assert property (p_start_needs_wel) else $error("start without latch");

	property p_hpm_refuses;
		cs_rise && opcode_q == `OPC_WRITE_STATUS && status_o[`SR_LOCK_BIT] && !sync_q.wp_b |=>
			!op_start_o.valid;
	endproperty
	a_hpm_refuses: assert property (p_hpm_refuses) else $error("status write in protection");

	property p_bulk_bp;
		cs_rise && opcode_q == `OPC_BULK_ERASE && status_o[`SR_BP_MSB:`SR_BP_LSB] != 3'h0 |=>
			!op_start_o.valid;
	endproperty
	a_bulk_bp: assert property (p_bulk_bp) else $error("bulk erase with protect bits");

	property p_id_busy;
		byte_end && state_q == ST_CMD && busy_q && rx_byte == `OPC_READ_ID |=> state_q == ST_SKIP;
	endproperty
	a_id_busy: assert property (p_id_busy) else $error("id read decoded while busy");

	property p_status_any;
		byte_end && state_q == ST_CMD && rx_byte == `OPC_READ_STATUS |=> state_q == ST_OUT;
	endproperty
	a_status_any: assert property (p_status_any) else $error("status read refused");

	property p_busy_holds;
		start_any |=> busy_q [*8];
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("busy bit dropped early");

	property p_bp_stable;
		!(busy_done && kind_q == OP_STATUS) |=> $stable(bp_q) && $stable(lock_q);
	endproperty
	a_bp_stable: assert property (p_bp_stable) else $error("protect bits changed");

	property p_len_byte;
		src_active_q && buf_in_ready && src_id_q && idx_q == `ID_IDX_LEN |->
			push_data == `ID_LEN_BYTE;
	endproperty
	a_len_byte: assert property (p_len_byte) else $error("length byte wrong");

	property p_standby;
		cs_rise |=> state_q == ST_IDLE && !miso_oe_o && !src_active_q;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby after deselect");

	property p_boundary;
		cs_rise && bit_q != 3'h0 && !busy_q |=> !op_start_o.valid && $stable(wel_q);
	endproperty
	a_boundary: assert property (p_boundary) else $error("off-boundary instruction ran");

	c_id_read: cover property (to_out && rx_byte == `OPC_READ_ID);
	c_status_busy: cover property (to_out && busy_q);
	c_status_write: cover property (start_sr);
	c_bulk_refused: cover property (at_boundary && opcode_q == `OPC_BULK_ERASE && !start_be);

endmodule

`default_nettype wire

//--- testbench/spi_host_model.sv
/*
 Host controller model for the serial link: chip select, mode 0 clock
 at 160 ns, data out and capture of the returned bits.
 Assumes the bench resolves the data-out wire and drives it on miso_i.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// Clock
	input wire logic mclk_i,
	// Link pins
	input wire logic miso_i,
	output var logic cs_b_o,
	output var logic sclk_o,
	output var logic mosi_o
);
	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	// Clock stands low outside frames, select released
	initial
	begin
		cs_b_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end

	// ----------------------------------------
	// One frame
	// ----------------------------------------
	// Sends ntx bits of tx left-aligned, then clocks nrx bits back.
	// A bit count that is not a whole byte is allowed on purpose.
	task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
		output logic [159:0] rx);
		int i;
		rx = '0;
		@(posedge mclk_i);
		cs_b_o <= 1'b0;
		for (i = 0; i < ntx + nrx; i++)
		begin
			// Unused data line toggles so that no stale level is read
			mosi_o <= (i < ntx) ? tx[39 - i] : i[0];
			repeat (8) @(posedge mclk_i);
			if (i >= ntx)
				rx = {rx[158:0], miso_i};
			sclk_o <= 1'b1;
			repeat (8) @(posedge mclk_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge mclk_i);
		// Release only after the last whole bit period
		cs_b_o <= 1'b1;
		mosi_o <= ~mosi_o;
		repeat (8) @(posedge mclk_i);
	endtask
endmodule

`default_nettype wire

//--- testbench/spi_flash_wel_id_status_logic_tb.sv
/*
 Self-checking bench of the flash command logic over its serial link.
 Assumes the constants header and package are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_consts.svh"

module spi_flash_wel_id_status_logic_tb;
	import spi_flash_pkg::*;
	// Short busy cycle keeps the run brief but outlasts two read frames
	localparam int unsigned BUSY_CYC = 1500;
	localparam logic [7:0] MAN = 8'h5b; // Arbitrary value
	localparam logic [7:0] TYP = 8'h61; // Arbitrary value
	localparam logic [7:0] CAP = 8'h0e; // Arbitrary value
	localparam logic [23:0] ADR = 24'h12a5f0;
	logic mclk_i, rst_b_i, cs_b, sclk, mosi, wp_b, prot_hit, miso, miso_oe;
	logic idle_pat, miso_w;
	logic [23:0] target_addr;
	logic [7:0] status;
	logic [159:0] rx;
	op_start_t op_start, last_op;
	int n_errors, comparisons, n_ops, oe_cnt, n0, o0;

	// ----------------------------------------
	// Instances and wire
	// ----------------------------------------
	spi_flash_wel_id_status_logic #(.BUSY_CYCLES(BUSY_CYC), .MANUF_CODE(MAN),
		.TYPE_CODE(TYP), .CAP_CODE(CAP)) spi_flash_wel_id_status_logic_i (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk),
		.mosi_i(mosi), .wp_b_i(wp_b), .miso_o(miso), .miso_oe_o(miso_oe),
		.prot_hit_i(prot_hit), .target_addr_o(target_addr),
		.op_start_o(op_start), .status_o(status));
	spi_host_model spi_host_model_i (.mclk_i(mclk_i), .miso_i(miso_w),
		.cs_b_o(cs_b), .sclk_o(sclk), .mosi_o(mosi));
	// Undriven data line shows a changing pattern, not the last bit
	assign miso_w = (miso_oe === 1'b1) ? miso : idle_pat;

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i)
	begin
		idle_pat <= ~idle_pat;
		if (op_start.valid === 1'b1)
		begin
			n_ops <= n_ops + 1;
			last_op <= op_start;
		end
		if (miso_oe === 1'b1)
			oe_cnt <= oe_cnt + 1;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [159:0] got, input logic [159:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic op(input logic [39:0] tx, input int ntx, input int nrx);
		spi_host_model_i.xfer(tx, ntx, nrx, rx);
	endtask

	task automatic cmd(input logic [7:0] c);
		op({c, 32'h0}, 8, 0);
	endtask

	// Bench watches the busy bit of status_o rather than sending into a running cycle
	task automatic wait_idle;
		int k;
		for (k = 0; k < 4000 && status[0] !== 1'b0; k++)
			@(posedge mclk_i);
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic wrap_up;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_latch;
		chk(status, 8'h00);
		cmd(`OPC_WRITE_ENABLE);
		chk(status, 8'h02);
		op({`OPC_READ_STATUS, 32'h0}, 8, 24);
		chk(rx[23:0], 24'h020202);
		cmd(`OPC_WRITE_DISABLE);
		chk(status, 8'h00);
		op({`OPC_WRITE_ENABLE, 32'h0}, 7, 0);
		chk(status, 8'h00);
		op({`OPC_WRITE_ENABLE, 32'h0}, 9, 0);
		chk(status, 8'h00);
		$display("t_latch done");
	endtask

	task automatic t_ident;
		op({`OPC_READ_ID, 32'h0}, 8, 160);
		chk(rx, {MAN, TYP, CAP, 8'h10, 128'h0});
		op({`OPC_READ_ID, 32'h0}, 8, 12);
		chk(miso_oe, 1'b0);
		op({`OPC_READ_STATUS, 32'h0}, 8, 8);
		chk(rx[7:0], 8'h00);
		$display("t_ident done");
	endtask

	task automatic t_busy;
		n0 = n_ops;
		cmd(`OPC_WRITE_ENABLE);
		cmd(`OPC_BULK_ERASE);
		chk(n_ops - n0, 1);
		chk(last_op.kind, OP_BULK);
		chk(status[0], 1'b1);
		o0 = oe_cnt;
		op({`OPC_READ_ID, 32'h0}, 8, 16);
		chk(oe_cnt - o0, 0);
		op({`OPC_READ_STATUS, 32'h0}, 8, 8);
		chk(rx[7:0], 8'h03);
		wait_idle();
		chk(status, 8'h00);
		$display("t_busy done");
	endtask

	task automatic t_protect;
		cmd(`OPC_WRITE_ENABLE);
		op({`OPC_WRITE_STATUS, 8'hfc, 24'h0}, 16, 0);
		wait_idle();
		chk(status, 8'h9c);
		@(posedge mclk_i);
		wp_b <= 1'b0;
		repeat (4) @(posedge mclk_i);
		cmd(`OPC_WRITE_ENABLE);
		n0 = n_ops;
		op({`OPC_WRITE_STATUS, 8'h00, 24'h0}, 16, 0);
		chk(n_ops - n0, 0);
		chk(status, 8'h9e);
		cmd(`OPC_BULK_ERASE);
		chk(n_ops - n0, 0);
		@(posedge mclk_i);
		prot_hit <= 1'b1;
		op({`OPC_PAGE_PROGRAM, ADR, 8'h5a}, 40, 0);
		chk(n_ops - n0, 0);
		@(posedge mclk_i);
		prot_hit <= 1'b0;
		op({`OPC_PAGE_PROGRAM, ADR, 8'h5a}, 40, 0);
		chk({last_op.kind, last_op.addr}, {OP_PROGRAM, ADR});
		chk(target_addr, ADR);
		wait_idle();
		op({`OPC_SECTOR_WIPE, ADR, 8'h00}, 32, 0);
		chk(n_ops - n0, 1);
		@(posedge mclk_i);
		wp_b <= 1'b1;
		repeat (4) @(posedge mclk_i);
		cmd(`OPC_WRITE_ENABLE);
		op({`OPC_WRITE_STATUS, 8'h00, 24'h0}, 16, 0);
		chk(last_op.kind, OP_STATUS);
		wait_idle();
		chk(status, 8'h00);
		$display("t_protect done");
	endtask

	task automatic t_wipe;
		n0 = n_ops;
		cmd(`OPC_WRITE_ENABLE);
		@(posedge mclk_i);
		prot_hit <= 1'b1;
		op({`OPC_SECTOR_WIPE, ADR, 8'h00}, 32, 0);
		chk(n_ops - n0, 0);
		@(posedge mclk_i);
		prot_hit <= 1'b0;
		op({`OPC_SECTOR_WIPE, ADR, 8'h00}, 32, 0);
		chk({last_op.kind, last_op.addr}, {OP_SECTOR, ADR});
		chk(status, 8'h03);
		wait_idle();
		chk(status, 8'h00);
		$display("t_wipe done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		n_errors = 0;
		comparisons = 0;
		n_ops = 0;
		oe_cnt = 0;
		idle_pat = 1'b0;
		rst_b_i = 1'b0;
		wp_b = 1'b1;
		prot_hit = 1'b0;
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		t_latch();
		t_ident();
		t_busy();
		t_protect();
		t_wipe();
		wrap_up();
	end

	// About 20k cycles expected; twice that is a hang
	initial
	begin
		#400000;
		n_errors++;
		wrap_up();
	end
endmodule

`default_nettype wire
